// ===== rtl/uart_irq_pkg.sv
// package: register map, field positions, reset values and types of the channel interrupt block
package uart_irq_pkg;

  // register offsets on the three address lines
  localparam logic [2:0] ADDR_TRG_FC = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_FEATURE_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_EFR = 3'h2;
  localparam logic [2:0] ADDR_RESUME_CHAR_ONE = 3'h4;
  localparam logic [2:0] ADDR_RESUME_CHAR_TWO = 3'h5;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_PAUSE_CHAR_ONE = 3'h6;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_PAUSE_CHAR_TWO = 3'h7;

  localparam logic [7:0] ENHANCED_KEY = 8'hBF;
  localparam int LCR_DIVISOR_BIT = 7;
  localparam int EFR_GATE_BIT = 4;
  localparam logic [7:0] MASK_GATED_BITS = 8'hF0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // interrupt source codes for status bits 5:0
  localparam logic [5:0] ISR_LINE = 6'h06;
  localparam logic [5:0] ISR_TIMEOUT = 6'h0C;
  localparam logic [5:0] ISR_RXDATA = 6'h04;
  localparam logic [5:0] ISR_TRANSMIT_READY_N = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // status coming from the uart core of this channel
  typedef struct packed {
    logic [7:0] rx_level;
    logic [7:0] rx_trigger;
    logic [7:0] tx_level;
    logic [7:0] tx_trigger;
    logic [7:0] modem_status;
    logic fifo_enable;
    logic char_loaded;
    logic overrun;
    logic head_parity;
    logic head_framing;
    logic head_break;
    logic fifo_error;
    logic thr_empty;
    logic tsr_empty;
    logic rx_timeout;
    logic modem_delta;
    logic xoff_rx;
    logic xon_rx;
    logic rts_pin;
    logic cts_pin;
  } core_status_t;

  // configuration handed back to the core
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] feature;
    logic [7:0] enhanced;
    logic [7:0] trigger;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] pause_one;
    logic [7:0] pause_two;
    logic trigger_wr;
  } chan_config_t;

endpackage

// ===== rtl/uart_irq_enable.sv
// module: per-channel interrupt mask, status and enhanced register logic
`timescale 1ns/100ps
module uart_irq_enable (
  input wire logic i_sys_clk, // 200 MHz clock
  input wire logic i_reset_n, // synchronous reset, active low
  input wire logic i_clk_en, // freezes all state while low
  input wire logic [2:0] i_addr, // register address lines
  input wire logic i_rd, // read strobe, one cycle
  input wire logic i_wr, // write strobe, one cycle
  input wire logic [7:0] i_wdata, // write data
  input wire logic [7:0] i_line_control, // line control register value
  input wire logic i_global_status_select_n, // low selects ready flag read
  input wire logic [3:0] i_all_rx_ready_n, // receive ready of channels D..A
  input wire logic [3:0] i_all_tx_ready_n, // transmit ready of channels D..A
  input wire logic [7:0] i_fifo_count, // fifo count read value
  input wire uart_irq_pkg::core_status_t i_core, // core status
  output logic [7:0] o_rdata, // read data, valid the cycle after i_rd
  output logic o_irq, // channel interrupt request, active high
  output logic o_rx_ready_n, // receive ready, active low
  output logic o_tx_ready_n, // transmit ready, active low
  output logic o_sleep_en, // sleep mode enable
  output logic o_thr_read_clr, // pulse: status read cleared sources
  output uart_irq_pkg::chan_config_t o_cfg // register contents to the core
);

  // ==========================================================
  // state
  typedef struct packed {
    uart_irq_pkg::chan_config_t cfg;
    logic overrun;
    logic line_pend;
    logic modem_pend;
    logic tx_pend;
    logic pause_pend;
    logic flow_pend;
    logic prev_rts;
    logic prev_cts;
    logic prev_tx_cond;
    logic [7:0] rdata;
    logic irq;
    logic rx_ready_n;
    logic tx_ready_n;
    logic read_clr;
  } state_t;

  state_t st;
  state_t next_st;

  logic enhanced_sel;
  logic std_sel;
  logic gate;
  logic rx_cond;
  logic tx_cond;
  logic line_event;
  logic [7:0] line_status;
  logic [7:0] isr_value;
  logic en_line;
  logic en_timeout;
  logic en_rx;
  logic en_tx;
  logic en_modem;
  logic en_pause;
  logic en_flow;
  logic rd_lsr;
  logic rd_msr;
  logic rd_isr;
  logic wr_mask;
  logic wr_thr;

  // ==========================================================
  // decode and source conditions
  always_comb begin
    enhanced_sel = (i_line_control == uart_irq_pkg::ENHANCED_KEY);
    std_sel = !i_line_control[uart_irq_pkg::LCR_DIVISOR_BIT];
    gate = st.cfg.enhanced[uart_irq_pkg::EFR_GATE_BIT];
    rd_lsr = i_rd && i_global_status_select_n && std_sel && (i_addr == uart_irq_pkg::ADDR_LSR);
    rd_msr = i_rd && i_global_status_select_n && std_sel && (i_addr == uart_irq_pkg::ADDR_MSR);
    rd_isr = i_rd && i_global_status_select_n && std_sel && (i_addr == uart_irq_pkg::ADDR_ISR);
    wr_mask = i_wr && std_sel && (i_addr == uart_irq_pkg::ADDR_MASK);
    wr_thr = i_wr && std_sel && (i_addr == uart_irq_pkg::ADDR_TRG_FC);
    // receive data: trigger level in fifo mode, any character otherwise
    if (i_core.fifo_enable) begin
      rx_cond = (i_core.rx_level >= i_core.rx_trigger);
    end else begin
      rx_cond = (i_core.rx_level != 8'h00);
    end
    if (i_core.fifo_enable) begin
      tx_cond = (i_core.tx_level < i_core.tx_trigger);
    end else begin
      tx_cond = i_core.thr_empty;
    end
    line_event = (i_core.char_loaded &&
                  (i_core.head_parity || i_core.head_framing || i_core.head_break))
                 || i_core.overrun;
    // data ready follows fifo occupancy, so it rises on the first load
    line_status[0] = (i_core.rx_level != 8'h00);
    line_status[1] = st.overrun;
    line_status[2] = i_core.head_parity;
    line_status[3] = i_core.head_framing;
    line_status[4] = i_core.head_break;
    line_status[5] = i_core.thr_empty;
    line_status[6] = i_core.thr_empty && i_core.tsr_empty;
    line_status[7] = i_core.fifo_error;
    // a mask bit only gates its source; pending flags keep running, except flow_pend, which sets only while mask bit 6 or 7 is on
    en_line = st.cfg.mask[2] && st.line_pend;
    en_timeout = st.cfg.mask[0] && i_core.rx_timeout;
    en_rx = st.cfg.mask[0] && rx_cond;
    en_tx = st.cfg.mask[1] && st.tx_pend;
    en_modem = st.cfg.mask[3] && st.modem_pend;
    en_pause = st.cfg.mask[5] && st.pause_pend;
    en_flow = (st.cfg.mask[6] || st.cfg.mask[7]) && st.flow_pend;
    isr_value[7:6] = {2{i_core.fifo_enable}};
    if (en_line) begin
      isr_value[5:0] = uart_irq_pkg::ISR_LINE;
    end else if (en_timeout) begin
      isr_value[5:0] = uart_irq_pkg::ISR_TIMEOUT;
    end else if (en_rx) begin
      isr_value[5:0] = uart_irq_pkg::ISR_RXDATA;
    end else if (en_tx) begin
      isr_value[5:0] = uart_irq_pkg::ISR_TRANSMIT_READY_N;
    end else if (en_modem) begin
      isr_value[5:0] = uart_irq_pkg::ISR_MODEM;
    end else if (en_pause) begin
      isr_value[5:0] = uart_irq_pkg::ISR_XOFF;
    end else if (en_flow) begin
      isr_value[5:0] = uart_irq_pkg::ISR_FLOW;
    end else begin
      isr_value[5:0] = uart_irq_pkg::ISR_NONE;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.cfg.trigger_wr = 1'b0;
    next_st.read_clr = 1'b0;
    // register writes
    if (i_wr) begin
      if (enhanced_sel) begin
        if (i_addr == uart_irq_pkg::ADDR_TRG_FC) begin
          next_st.cfg.trigger = i_wdata;
          next_st.cfg.trigger_wr = 1'b1;
        end else if (i_addr == uart_irq_pkg::ADDR_FEATURE_CONTROL) begin
          next_st.cfg.feature = i_wdata;
        end else if (i_addr == uart_irq_pkg::ADDR_EFR) begin
          next_st.cfg.enhanced = i_wdata;
        end else if (i_addr == uart_irq_pkg::ADDR_RESUME_CHAR_ONE) begin
          next_st.cfg.resume_one = i_wdata;
        end else if (i_addr == uart_irq_pkg::ADDR_RESUME_CHAR_TWO) begin
          next_st.cfg.resume_two = i_wdata;
        end else if (i_addr == uart_irq_pkg::ADDR_PAUSE_CHAR_ONE) begin
          next_st.cfg.pause_one = i_wdata;
        end else if (i_addr == uart_irq_pkg::ADDR_PAUSE_CHAR_TWO) begin
          next_st.cfg.pause_two = i_wdata;
        end
      end else if (wr_mask) begin
        // upper nibble keeps its value unless the enhanced gate is open
        if (gate) begin
          next_st.cfg.mask = i_wdata;
        end else begin
          next_st.cfg.mask = (st.cfg.mask & uart_irq_pkg::MASK_GATED_BITS)
                             | (i_wdata & ~uart_irq_pkg::MASK_GATED_BITS);
        end
      end
    end
    // sticky overrun, cleared by a line status read; a new event wins
    if (rd_lsr) begin
      next_st.overrun = 1'b0;
      next_st.line_pend = 1'b0;
    end
    if (i_core.overrun) begin
      next_st.overrun = 1'b1;
    end
    if (line_event) begin
      next_st.line_pend = 1'b1;
    end
    if (rd_msr) begin
      next_st.modem_pend = 1'b0;
      next_st.flow_pend = 1'b0;
    end
    if (i_core.modem_delta) begin
      next_st.modem_pend = 1'b1;
    end
    next_st.prev_rts = i_core.rts_pin;
    next_st.prev_cts = i_core.cts_pin;
    if ((st.cfg.mask[6] && i_core.rts_pin && !st.prev_rts) ||
        (st.cfg.mask[7] && i_core.cts_pin && !st.prev_cts)) begin
      next_st.flow_pend = 1'b1;
    end
    // transmit ready: cleared by a status read or a holding write
    next_st.prev_tx_cond = tx_cond;
    if (rd_isr || wr_thr) begin
      next_st.tx_pend = 1'b0;
    end
    if (tx_cond && !st.prev_tx_cond) begin
      next_st.tx_pend = 1'b1;
    end
    if (wr_mask && i_wdata[1] && !st.cfg.mask[1] && tx_cond) begin
      next_st.tx_pend = 1'b1;
    end
    // pause character: cleared by a status read or a resume character
    if (rd_isr || i_core.xon_rx) begin
      next_st.pause_pend = 1'b0;
    end
    if (i_core.xoff_rx) begin
      next_st.pause_pend = 1'b1;
    end
    next_st.read_clr = rd_isr || rd_lsr || rd_msr;
    // read data path, registered one cycle after the strobe
    if (i_rd) begin
      if (!i_global_status_select_n) begin
        next_st.rdata = {i_all_rx_ready_n, i_all_tx_ready_n};
      end else if (enhanced_sel) begin
        if (i_addr == uart_irq_pkg::ADDR_TRG_FC) begin
          next_st.rdata = i_fifo_count;
        end else if (i_addr == uart_irq_pkg::ADDR_FEATURE_CONTROL) begin
          next_st.rdata = st.cfg.feature;
        end else if (i_addr == uart_irq_pkg::ADDR_EFR) begin
          next_st.rdata = st.cfg.enhanced;
        end else if (i_addr == uart_irq_pkg::ADDR_RESUME_CHAR_ONE) begin
          next_st.rdata = st.cfg.resume_one;
        end else if (i_addr == uart_irq_pkg::ADDR_RESUME_CHAR_TWO) begin
          next_st.rdata = st.cfg.resume_two;
        end else if (i_addr == uart_irq_pkg::ADDR_PAUSE_CHAR_ONE) begin
          next_st.rdata = st.cfg.pause_one;
        end else if (i_addr == uart_irq_pkg::ADDR_PAUSE_CHAR_TWO) begin
          next_st.rdata = st.cfg.pause_two;
        end else begin
          next_st.rdata = 8'h00;
        end
      end else if (std_sel) begin
        // polled mode reads these without any interrupt enabled
        if (i_addr == uart_irq_pkg::ADDR_MASK) begin
          next_st.rdata = st.cfg.mask;
        end else if (i_addr == uart_irq_pkg::ADDR_ISR) begin
          next_st.rdata = isr_value;
        end else if (i_addr == uart_irq_pkg::ADDR_LSR) begin
          next_st.rdata = line_status;
        end else if (i_addr == uart_irq_pkg::ADDR_MSR) begin
          next_st.rdata = i_core.modem_status;
        end else begin
          next_st.rdata = 8'h00;
        end
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    next_st.irq = en_line || en_timeout || en_rx || en_tx || en_modem
                  || en_pause || en_flow;
    next_st.rx_ready_n = !rx_cond;
    next_st.tx_ready_n = !tx_cond;
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.cfg.mask <= uart_irq_pkg::MASK_RESET;
      st.cfg.feature <= uart_irq_pkg::REG_RESET;
      st.cfg.enhanced <= uart_irq_pkg::REG_RESET;
      st.rx_ready_n <= 1'b1;
      st.tx_ready_n <= 1'b1;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_rx_ready_n = st.rx_ready_n;
  assign o_tx_ready_n = st.tx_ready_n;
  assign o_sleep_en = st.cfg.mask[4];
  assign o_thr_read_clr = st.read_clr;
  assign o_cfg = st.cfg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  chk_mask_reset: assert property ($rose(i_reset_n) |-> st.cfg.mask == 8'h00)
    else $error("mask not zero after reset");
  chk_gated_mask: assert property (i_clk_en && wr_mask && !gate && !enhanced_sel
    |=> st.cfg.mask[7:4] == $past(st.cfg.mask[7:4]))
    else $error("gated mask bits changed without enhanced gate");
  chk_efr_key: assert property (i_clk_en && i_wr && i_addr == 3'h2 && i_line_control != 8'hBF
    |=> $stable(st.cfg.enhanced))
    else $error("enhanced register written without key");
  chk_irq_or: assert property (i_clk_en |=> o_irq == $past(en_line || en_timeout || en_rx
    || en_tx || en_modem || en_pause || en_flow))
    else $error("interrupt not the or of enabled sources");
  chk_lsr_clear: assert property (i_clk_en && rd_lsr && !line_event
    |=> !st.line_pend && !st.overrun)
    else $error("line status read did not clear");
  chk_line_set: assert property (i_clk_en && line_event
    |=> st.line_pend and (st.cfg.mask[2] |=> (o_irq || !$past(i_clk_en))))
    else $error("errored character lost");
  chk_idle_isr: assert property (!o_irq && i_clk_en && rd_isr
    && $past(i_clk_en) && $stable(isr_value) |=> o_rdata[0] == 1'b1)
    else $error("idle status bit 0 not one");
  chk_tx_enable: assert property (i_clk_en && wr_mask && i_wdata[1] && !st.cfg.mask[1]
    && tx_cond |=> st.tx_pend)
    else $error("enable while empty gave no transmit interrupt");
  chk_global: assert property (i_clk_en && i_rd && !i_global_status_select_n
    |=> o_rdata == $past({i_all_rx_ready_n, i_all_tx_ready_n}))
    else $error("global ready flags read wrong");
  chk_lsr_bits: assert property (i_clk_en && rd_lsr
    |=> o_rdata[6] == ($past(i_core.thr_empty) && $past(i_core.tsr_empty)))
    else $error("line status bit 6 wrong");
  chk_modem_mask: assert property (!st.cfg.mask[3] && i_clk_en && rd_isr
    |=> o_rdata[3:0] != 4'h0 || o_rdata[5:4] != 2'b00)
    else $error("masked modem source reported");

  cov_rx_trigger: cover property (i_core.fifo_enable && st.cfg.mask[0] && o_irq);
  cov_line_irq: cover property (line_event ##1 rd_lsr);
  cov_flow_irq: cover property (st.cfg.mask[7] && $rose(i_core.cts_pin) ##2 o_irq);
  cov_global: cover property (i_rd && !i_global_status_select_n);

endmodule

// ===== verif/uart_core_model.sv
// core-side status model feeding the channel interrupt block
`timescale 1ns/100ps
module uart_core_model (
  input wire logic i_sys_clk, // system clock
  output uart_irq_pkg::core_status_t o_core // status toward the block
);
  uart_irq_pkg::core_status_t st;
  assign o_core = st;
  initial begin
    st = '0;
    st.thr_empty = 1'b1;
    st.tsr_empty = 1'b1;
  end
  // =====================================================
  // receive side: level and load pulse move together
  task automatic push();
    @(posedge i_sys_clk);
    #1;
    st.rx_level = st.rx_level + 8'h01;
    st.char_loaded = 1'b1;
    @(posedge i_sys_clk);
    #1;
    st.char_loaded = 1'b0;
  endtask
  task automatic pop();
    @(posedge i_sys_clk);
    #1;
    st.rx_level = st.rx_level - 8'h01;
  endtask
  // one-cycle event: 0 overrun, 1 modem change, 2 pause character
  task automatic pulse(input int sel);
    @(posedge i_sys_clk);
    #1;
    if (sel == 0) st.overrun = 1'b1;
    if (sel == 1) st.modem_delta = 1'b1;
    if (sel == 2) st.xoff_rx = 1'b1;
    @(posedge i_sys_clk);
    #1;
    st.overrun = 1'b0;
    st.modem_delta = 1'b0;
    st.xoff_rx = 1'b0;
  endtask
endmodule

// ===== verif/uart_irq_enable_test.sv
// self-checking bench for the channel interrupt block
`timescale 1ns/100ps
module uart_irq_enable_test;
  logic i_sys_clk = 1'b0;
  logic i_reset_n, i_clk_en, i_rd, i_wr, i_global_status_select_n;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, i_line_control, i_fifo_count;
  logic [3:0] i_all_rx_ready_n, i_all_tx_ready_n;
  logic [7:0] o_rdata;
  logic o_irq, o_rx_ready_n, o_tx_ready_n, o_sleep_en, o_thr_read_clr;
  uart_irq_pkg::core_status_t core;
  uart_irq_pkg::chan_config_t cfg;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  uart_core_model uart_core_model_i (.i_sys_clk(i_sys_clk), .o_core(core));
  uart_irq_enable uart_irq_enable_i (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .i_line_control(i_line_control),
    .i_global_status_select_n(i_global_status_select_n),
    .i_all_rx_ready_n(i_all_rx_ready_n), .i_all_tx_ready_n(i_all_tx_ready_n),
    .i_fifo_count(i_fifo_count), .i_core(core), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_rx_ready_n(o_rx_ready_n), .o_tx_ready_n(o_tx_ready_n), .o_sleep_en(o_sleep_en),
    .o_thr_read_clr(o_thr_read_clr), .o_cfg(cfg));
  // =====================================================
  // verdict, comparisons and bus cycles
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_wr = 1'b0;
  endtask
  // read data is registered, so it is compared one edge after the strobe drops
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    #1;
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_rd = 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk8(o_rdata, exp);
  endtask
  // allows the core model's edge plus the registered request stage
  task automatic irq(input logic exp);
    repeat (3) @(posedge i_sys_clk);
    #1;
    chk1(o_irq, exp);
  endtask
  // ceiling well above the roughly 200 cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  // =====================================================
  // test sequence
  initial begin
    i_reset_n = 1'b0;
    i_clk_en = 1'b1;
    i_addr = 3'h0;
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_wdata = 8'h00;
    i_line_control = 8'h03;
    i_global_status_select_n = 1'b1;
    i_all_rx_ready_n = 4'hF;
    i_all_tx_ready_n = 4'hF;
    i_fifo_count = 8'h3C;
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    rd(uart_irq_pkg::ADDR_MASK, 8'h00);
    chk1(o_tx_ready_n, 1'b0);
    rd(uart_irq_pkg::ADDR_ISR, 8'h01);
    rd(uart_irq_pkg::ADDR_LSR, 8'h60);
    rd(3'h3, 8'h00);
    wr(uart_irq_pkg::ADDR_MASK, 8'hF0);
    rd(uart_irq_pkg::ADDR_MASK, 8'h00);
    wr(uart_irq_pkg::ADDR_MASK, 8'h02);
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h02);
    irq(1'b0);
    wr(uart_irq_pkg::ADDR_MASK, 8'h01);
    uart_core_model_i.push();
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h04);
    rd(uart_irq_pkg::ADDR_LSR, 8'h61);
    uart_core_model_i.pop();
    irq(1'b0);
    rd(uart_irq_pkg::ADDR_LSR, 8'h60);
    wr(uart_irq_pkg::ADDR_MASK, 8'h04);
    uart_core_model_i.pulse(0);
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h06);
    rd(uart_irq_pkg::ADDR_LSR, 8'h62);
    irq(1'b0);
    uart_core_model_i.st.head_parity = 1'b1;
    uart_core_model_i.st.fifo_error = 1'b1;
    uart_core_model_i.push();
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_LSR, 8'hE5);
    uart_core_model_i.st.head_parity = 1'b0;
    uart_core_model_i.st.fifo_error = 1'b0;
    uart_core_model_i.pop();
    wr(uart_irq_pkg::ADDR_MASK, 8'h00);
    uart_core_model_i.pulse(1);
    irq(1'b0);
    wr(uart_irq_pkg::ADDR_MASK, 8'h08);
    uart_core_model_i.pulse(1);
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h00);
    rd(uart_irq_pkg::ADDR_MSR, 8'h00);
    irq(1'b0);
    // enhanced page opens only under the key value
    i_line_control = uart_irq_pkg::ENHANCED_KEY;
    wr(uart_irq_pkg::ADDR_EFR, 8'h10);
    wr(uart_irq_pkg::ADDR_FEATURE_CONTROL, 8'hA5);
    for (int a = 4; a < 8; a++) wr(a[2:0], 8'h80 + a[7:0]);
    rd(uart_irq_pkg::ADDR_EFR, 8'h10);
    rd(uart_irq_pkg::ADDR_FEATURE_CONTROL, 8'hA5);
    for (int a = 4; a < 8; a++) rd(a[2:0], 8'h80 + a[7:0]);
    rd(uart_irq_pkg::ADDR_TRG_FC, 8'h3C);
    wr(uart_irq_pkg::ADDR_TRG_FC, 8'h2A);
    chk8(cfg.trigger, 8'h2A);
    chk1(cfg.trigger_wr, 1'b1);
    i_line_control = 8'h03;
    wr(uart_irq_pkg::ADDR_MASK, 8'hC0);
    rd(uart_irq_pkg::ADDR_MASK, 8'hC0);
    @(posedge i_sys_clk);
    #1;
    uart_core_model_i.st.cts_pin = 1'b1;
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h20);
    rd(uart_irq_pkg::ADDR_MSR, 8'h00);
    irq(1'b0);
    wr(uart_irq_pkg::ADDR_MASK, 8'h30);
    chk1(o_sleep_en, 1'b1);
    uart_core_model_i.pulse(2);
    irq(1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'h10);
    irq(1'b0);
    uart_core_model_i.st.fifo_enable = 1'b1;
    uart_core_model_i.st.rx_trigger = 8'h02;
    wr(uart_irq_pkg::ADDR_MASK, 8'h01);
    uart_core_model_i.push();
    irq(1'b0);
    uart_core_model_i.push();
    irq(1'b1);
    chk1(o_rx_ready_n, 1'b0);
    rd(uart_irq_pkg::ADDR_ISR, 8'hC4);
    uart_core_model_i.pop();
    irq(1'b0);
    chk1(o_rx_ready_n, 1'b1);
    rd(uart_irq_pkg::ADDR_ISR, 8'hC1);
    wr(uart_irq_pkg::ADDR_MASK, 8'h00);
    irq(1'b0);
    rd(uart_irq_pkg::ADDR_LSR, 8'h61);
    i_global_status_select_n = 1'b0;
    i_all_rx_ready_n = 4'hA;
    i_all_tx_ready_n = 4'h5;
    rd(3'h3, 8'hA5);
    conclude();
  end
endmodule
